// ===== common/rxlp_defines.vh
`ifndef RXLP_DEFINES_VH
`define RXLP_DEFINES_VH

// Stage delays in serial bit times (one bit time per mclk_i cycle with ce_i high)
`define RXLP_A_MIN      8'd47
`define RXLP_A_SPAN     4'd10
`define RXLP_B_DLY      8'd10
`define RXLP_C_DLY      8'd10
`define RXLP_D_MIN      8'd10
`define RXLP_D_SPAN     4'd10
`define RXLP_E_DLY      8'd10
`define RXLP_F_DLY      8'd10
`define RXLP_G_DLY      8'd10
`define RXLP_H_MIN      8'd10
`define RXLP_H_SPAN     5'd30
`define RXLP_I_MIN      8'd10
`define RXLP_I_SPAN     4'd10

// Delay line and word sizes
`define RXLP_LINE_LEN   192
`define RXLP_WORD_W     20
`define RXLP_CNT_W      5
`define RXLP_WORD_LAST  5'd19
`define RXLP_SEED_W     17
`define RXLP_TAP_OFS    8'd2

// Spread seed fields
`define RXLP_SA_HI      3
`define RXLP_SA_LO      0
`define RXLP_SD_HI      7
`define RXLP_SD_LO      4
`define RXLP_SH_HI      12
`define RXLP_SH_LO      8
`define RXLP_SI_HI      16
`define RXLP_SI_LO      13

`endif

// ===== rtl/rxlp_pipeline.v
`timescale 1ns/100ps
`include "rxlp_defines.vh"

// Operation
// R1 - Line bit reaches deserializer register 47 to 57 bit times later.
// R2 - Deserializer to phy alignment stage takes exactly 10 bit times.
// R3 - Decoder output to receive FIFO input takes exactly 10 bit times.
// R4 - FIFO output to parallel output register takes 10 to 20 bit times; the code gives 0 to 10 when the FIFO is bypassed.
// R5 - Decoder off removes the decoder stage, exactly 20 bit times shorter.
// R6 - Absolute latency may differ after each reset, within a bounded spread.
// R7 - Separate settings bypass channel sync, decoder and FIFO stages.
module rxlp_pipeline
(
  // Clock, reset, enable
  input  wire                       mclk_i,
  input  wire                       reset_n_i,
  input  wire                       ce_i,
  // Configuration, captured at reset release
  input  wire                       sync_en_i,
  input  wire                       dec_en_i,
  input  wire                       fifo_en_i,
  input  wire [`RXLP_SEED_W-1:0]    lat_seed_i,
  // Serial line input
  input  wire                       line_bit_i,
  input  wire                       line_vld_i,
  // Parallel output toward host
  output wire                       rx_bit_o,
  output wire                       rx_bit_vld_o,
  output wire [`RXLP_WORD_W-1:0]    rx_word_o,
  output wire                       rx_word_vld_o,
  output wire [7:0]                 rx_latency_o
);

  // ==========================================================
  // Configuration and spread capture
  // ==========================================================
  reg                        rst_d_r;
  reg                        sync_en_r;
  reg                        dec_en_r;
  reg                        fifo_en_r;
  reg  [3:0]                 ext_a_r;
  reg  [3:0]                 ext_d_r;
  reg  [4:0]                 ext_h_r;
  reg  [3:0]                 ext_i_r;
  reg  [7:0]                 total_r;
  reg                        cfg_ok_r;

  wire [3:0] sa = lat_seed_i[`RXLP_SA_HI:`RXLP_SA_LO];
  wire [3:0] sd = lat_seed_i[`RXLP_SD_HI:`RXLP_SD_LO];
  wire [4:0] sh = lat_seed_i[`RXLP_SH_HI:`RXLP_SH_LO];
  wire [3:0] si = lat_seed_i[`RXLP_SI_HI:`RXLP_SI_LO];

  // Per-reset spread, clamped to each stage's range
  wire [3:0] ea_nxt;
  wire [3:0] ed_nxt;
  wire [4:0] eh_nxt;
  wire [3:0] ei_nxt;

  rxlp_clamp #(.W(4)) u_clamp_a                               // [R6]
  (
    .val_i (sa),
    .lim_i (`RXLP_A_SPAN),
    .res_o (ea_nxt)
  );

  rxlp_clamp #(.W(4)) u_clamp_d                               // [R6]
  (
    .val_i (sd),
    .lim_i (`RXLP_D_SPAN),
    .res_o (ed_nxt)
  );

  rxlp_clamp #(.W(5)) u_clamp_h                               // [R6]
  (
    .val_i (sh),
    .lim_i (`RXLP_H_SPAN),
    .res_o (eh_nxt)
  );

  rxlp_clamp #(.W(4)) u_clamp_i                               // [R6]
  (
    .val_i (si),
    .lim_i (`RXLP_I_SPAN),
    .res_o (ei_nxt)
  );

  always @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      rst_d_r   <= 1'b1;
      sync_en_r <= 1'b1;
      dec_en_r  <= 1'b1;
      fifo_en_r <= 1'b1;
      ext_a_r   <= 4'h0;
      ext_d_r   <= 4'h0;
      ext_h_r   <= 5'h00;
      ext_i_r   <= 4'h0;
    end
    else if (ce_i)
    begin
      rst_d_r <= 1'b0;
      // Strap-style capture on first enabled cycle after release
      if (rst_d_r)
      begin
        sync_en_r <= sync_en_i; // [R7]
        dec_en_r  <= dec_en_i;  // [R7]
        fifo_en_r <= fifo_en_i; // [R7]
        ext_a_r   <= ea_nxt;
        ext_d_r   <= ed_nxt;
        ext_h_r   <= eh_nxt;
        ext_i_r   <= ei_nxt;
      end
    end
  end

  // ==========================================================
  // Stage delay sum
  // ==========================================================
  wire [7:0] dly_a  = `RXLP_A_MIN + {4'h0, ext_a_r};                // [R1]
  wire [7:0] dly_b  = `RXLP_B_DLY;                                  // [R2]
  wire [7:0] dly_cd = sync_en_r ?
                      (`RXLP_C_DLY + `RXLP_D_MIN + {4'h0, ext_d_r}) :
                      8'h00;                                        // [R7]
  wire [7:0] dly_ef = dec_en_r ? (`RXLP_E_DLY + `RXLP_F_DLY) :
                      8'h00;                                        // [R5]
  wire [7:0] dly_g  = `RXLP_G_DLY;                                  // [R3]
  wire [7:0] dly_h  = fifo_en_r ?
                      (`RXLP_H_MIN + {3'h0, ext_h_r} + `RXLP_I_MIN) :
                      8'h00;                                        // [R7]
  wire [7:0] dly_i  = {4'h0, ext_i_r};                              // [R4]
  wire [7:0] total_nxt = dly_a + dly_b + dly_cd + dly_ef + dly_g
                         + dly_h + dly_i;

  always @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      total_r  <= `RXLP_A_MIN;
      cfg_ok_r <= 1'b0;
    end
    else if (ce_i)
    begin
      total_r  <= total_nxt;
      cfg_ok_r <= ~rst_d_r;
    end
  end

  // ==========================================================
  // Bit delay line and parallel output register
  // ==========================================================
  reg  [`RXLP_LINE_LEN-1:0]  bit_line_r;
  reg  [`RXLP_LINE_LEN-1:0]  vld_line_r;
  reg                        out_bit_r;
  reg                        out_vld_r;
  reg  [`RXLP_WORD_W-1:0]    shift_r;
  reg  [`RXLP_WORD_W-1:0]    word_r;
  reg                        word_vld_r;
  reg  [`RXLP_CNT_W-1:0]     cnt_r;

  // Tap two back: line stage plus output register make total
  wire [7:0] tap = total_r - `RXLP_TAP_OFS;

  always @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      bit_line_r <= {`RXLP_LINE_LEN{1'b0}};
      vld_line_r <= {`RXLP_LINE_LEN{1'b0}};
      out_bit_r  <= 1'b0;
      out_vld_r  <= 1'b0;
      shift_r    <= {`RXLP_WORD_W{1'b0}};
      word_r     <= {`RXLP_WORD_W{1'b0}};
      word_vld_r <= 1'b0;
      cnt_r      <= {`RXLP_CNT_W{1'b0}};
    end
    else if (ce_i)
    begin
      bit_line_r <= {bit_line_r[`RXLP_LINE_LEN-2:0], line_bit_i};
      vld_line_r <= {vld_line_r[`RXLP_LINE_LEN-2:0],
                     line_vld_i & cfg_ok_r};
      out_bit_r  <= bit_line_r[tap];                   // [R1] [R4] [R6]
      out_vld_r  <= vld_line_r[tap];
      word_vld_r <= 1'b0;
      if (out_vld_r)
      begin
        // First received bit lands in the top position
        shift_r <= {shift_r[`RXLP_WORD_W-2:0], out_bit_r};
        if (cnt_r == `RXLP_WORD_LAST)
        begin
          cnt_r      <= {`RXLP_CNT_W{1'b0}};
          word_r     <= {shift_r[`RXLP_WORD_W-2:0], out_bit_r};
          word_vld_r <= 1'b1;
        end
        else
          cnt_r <= cnt_r + 5'd1;
      end
    end
  end

  assign rx_bit_o      = out_bit_r;
  assign rx_bit_vld_o  = out_vld_r;
  assign rx_word_o     = word_r;
  assign rx_word_vld_o = word_vld_r;
  assign rx_latency_o  = total_r;

endmodule // rxlp_pipeline

// ==========================================================
// Saturating clamp of a seed field to a stage span
// ==========================================================
module rxlp_clamp
#(
  parameter W = 4
)
(
  // Field and its ceiling
  input  wire [W-1:0]               val_i,
  input  wire [W-1:0]               lim_i,
  // Clamped value
  output wire [W-1:0]               res_o
);

  assign res_o = (val_i > lim_i) ? lim_i : val_i;

endmodule // rxlp_clamp

// ===== tb/rxlp_checker.sv
`timescale 1ns/100ps
// ==========
// Port checker
module rxlp_checker
(
  // Clock and reset
  input wire        mclk_i,
  input wire        reset_n_i,
  // Watched configuration
  input wire        dec_en_i,
  input wire        fifo_en_i,
  // Watched outputs
  input wire        rx_bit_vld_o,
  input wire [19:0] rx_word_o,
  input wire        rx_word_vld_o,
  input wire [7:0]  rx_latency_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_up; reset_n_i [*5]; endsequence
  property p_range; s_up |-> rx_latency_o inside {[67:187]}; endproperty
  property p_hold; s_up |-> $stable(rx_latency_o); endproperty
  property p_dec_on; s_up ##0 dec_en_i |-> rx_latency_o >= 8'd87; endproperty
  property p_dec_off; s_up ##0 !dec_en_i |-> rx_latency_o <= 8'd167;
  endproperty
  property p_fifo_off; s_up ##0 !fifo_en_i |-> rx_latency_o <= 8'd137;
  endproperty
  property p_pulse; rx_word_vld_o |=> !rx_word_vld_o [*8]; endproperty
  property p_after; rx_word_vld_o |-> $past(rx_bit_vld_o); endproperty
  property p_whold; !rx_word_vld_o |-> $stable(rx_word_o); endproperty
  a_range: assert property (p_range) else $error("bad latency");
  a_hold: assert property (p_hold) else $error("latency moved");
  a_dec_on: assert property (p_dec_on) else $error("decoder short");
  a_dec_off: assert property (p_dec_off) else $error("decoder kept");
  a_fifo_off: assert property (p_fifo_off) else $error("fifo kept");
  a_pulse: assert property (p_pulse) else $error("word pulse long");
  a_after: assert property (p_after) else $error("word without bit");
  a_whold: assert property (p_whold) else $error("word moved");
endmodule // rxlp_checker
bind rxlp_pipeline rxlp_checker u_chk (
  .mclk_i        (mclk_i),
  .reset_n_i     (reset_n_i),
  .dec_en_i      (dec_en_i),
  .fifo_en_i     (fifo_en_i),
  .rx_bit_vld_o  (rx_bit_vld_o),
  .rx_word_o     (rx_word_o),
  .rx_word_vld_o (rx_word_vld_o),
  .rx_latency_o  (rx_latency_o)
);

// ===== tb/rxlp_host_model.sv
`timescale 1ns/100ps
// Host side: counts received words
module rxlp_host_model
(
  input  wire        mclk_i,
  input  wire        rx_word_vld_o,
  output reg  [15:0] words_o
);
  initial words_o = 16'h0;
  always @(posedge mclk_i)
    if (rx_word_vld_o)
      words_o <= words_o + 16'h1;
endmodule // rxlp_host_model

// ===== tb/test_rx_path_latency_pipeline.sv
`timescale 1ns/100ps
`include "rxlp_defines.vh"
`define CK(n,e,g) begin ev = e; gv = g; checks++; if (gv !== ev) begin \
  err_total++; $display("BAD %s exp %0d got %0d", n, ev, gv); end end
module test_rx_path_latency_pipeline;
  reg         mclk_i = 0, reset_n_i = 0, line_bit_i = 0, line_vld_i = 0;
  reg         sync_en_i = 1, dec_en_i = 1, fifo_en_i = 1;
  reg  [16:0] lat_seed_i = 0;
  reg  [31:0] rs = 25174, ev, gv;
  reg  [19:0] w;
  integer     err_total = 0, checks = 0, cyc = 0, lx, nw = 0, nb = 0, k;
  integer     tq[$];
  reg         bq[$];
  reg  [19:0] wq[$];
  wire        rx_bit_o, rx_bit_vld_o, rx_word_vld_o;
  wire [19:0] rx_word_o;
  wire [7:0]  rx_latency_o;
  wire [15:0] hw;
  always #5 mclk_i = ~mclk_i;
  rxlp_pipeline DUT (.mclk_i, .reset_n_i, .ce_i(1'b1), .sync_en_i, .dec_en_i,
    .fifo_en_i, .lat_seed_i, .line_bit_i, .line_vld_i, .rx_bit_o,
    .rx_bit_vld_o, .rx_word_o, .rx_word_vld_o, .rx_latency_o);
  rxlp_host_model u_host (.mclk_i, .rx_word_vld_o, .words_o(hw));
  function [31:0] xs(input [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction
  task end_of_test;
    begin
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // ==========
  // Reference model
  always @(posedge mclk_i)
  begin
    cyc = cyc + 1;
    if (cyc > 9000)
    begin
      err_total++;
      end_of_test;
    end
    if (rx_word_vld_o)
      `CK("word", wq.pop_front(), rx_word_o)
    if (rx_bit_vld_o)
    begin
      `CK("delay", lx, cyc - tq.pop_front())
      `CK("bit", bq.pop_front(), rx_bit_o)
      w = {w[18:0], ev[0]};
      nb++;
      if (nb == 20)
      begin
        wq.push_back(w);
        nw++;
        nb = 0;
      end
    end
    // Outputs seen at the reset edge were launched before it
    if (!reset_n_i)
    begin
      nw -= wq.size();
      tq.delete();
      bq.delete();
      wq.delete();
      nb = 0;
    end
    if (line_vld_i && reset_n_i)
    begin
      tq.push_back(cyc);
      bq.push_back(line_bit_i);
    end
  end
  task run(input [2:0] c, input [16:0] sd, input dr);
    integer a, d, h, t;
    begin
      {sync_en_i, dec_en_i, fifo_en_i} = c;
      lat_seed_i = sd;
      reset_n_i = 0;
      repeat (4) @(posedge mclk_i);
      #1 reset_n_i = 1;
      a = sd[3:0] > 10 ? 10 : sd[3:0];
      d = sd[7:4] > 10 ? 10 : sd[7:4];
      h = sd[12:8] > 30 ? 30 : sd[12:8];
      t = sd[16:13] > 10 ? 10 : sd[16:13];
      lx = 67 + a + (c[2] ? 20 + d : 0) + (c[1] ? 20 : 0)
        + (c[0] ? 20 + h : 0) + t;
      repeat (3) @(posedge mclk_i);
      #1 `CK("lat", lx, rx_latency_o)
      repeat (300)
      begin
        @(posedge mclk_i);
        #1 rs = xs(rs);
        line_bit_i = rs[0];
        line_vld_i = rs[1] | rs[2];
      end
      @(posedge mclk_i);
      #1 line_vld_i = 0;
      if (dr)
      begin
        repeat (220) @(posedge mclk_i);
        #1 `CK("left", 0, tq.size())
        `CK("host", nw, hw)
      end
    end
  endtask
  initial
  begin
    for (k = 0; k < 10; k++)
    begin
      rs = xs(rs);
      run(k[2:0] ^ {3{k[3] & k[0]}}, k < 8 ? rs[16:0] : '1, k != 3);
    end
    end_of_test;
  end
endmodule // test_rx_path_latency_pipeline
